// ---- mcet_error_table.sv ----
// Command error table writer with database and processor read window
`default_nettype none
module mcet_error_table
  import mcet_pkg::*;
#(
  parameter int unsigned DEPTH = DB_WORDS
) (
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire logic              warm_restart_request_i,
  input  wire logic              cold_restart_request_i,
  input  wire mcet_config_t      config_i,
  input  wire logic [15:0]       max_address_i,
  input  wire logic              entry_valid_i,
  input  wire logic [IDX_W-1:0]  entry_index_i,
  input  wire mcet_entry_t       master_command_entry_i,
  input  wire logic              result_valid_i,
  input  wire mcet_result_t      result_i,
  input  wire logic              proc_read_i,
  input  wire logic [ADDR_W-1:0] proc_index_i,
  output logic                   proc_valid_o,
  output logic [WORD_W-1:0]      processor_read_array_o,
  output logic                   proc_in_window_o,
  output logic                   config_loaded_o,
  output logic [WORD_W-1:0]      last_code_o,
  output logic                   write_strobe_o,
  output logic [ADDR_W-1:0]      write_address_o
);
  logic [WORD_W-1:0] mem_q [DEPTH];
  mcet_config_t cfg_q;
  logic         load_pending_q;
  logic [2:0]   warm_q;
  logic [2:0]   cold_q;

  // Restart toggles come from the processor domain
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      warm_q <= 3'h0;
      cold_q <= 3'h0;
    end else begin
      warm_q <= {warm_q[1:0], warm_restart_request_i};
      cold_q <= {cold_q[1:0], cold_restart_request_i};
    end
  end

  logic warm_stable_q;
  logic cold_stable_q;
  wire warm_agree_w  = (warm_q[1] == warm_q[2]);
  wire cold_agree_w  = (cold_q[1] == cold_q[2]);
  wire warm_change_w = warm_agree_w && (warm_q[2] != warm_stable_q);
  wire cold_change_w = cold_agree_w && (cold_q[2] != cold_stable_q);
  wire restart_w     = warm_change_w || cold_change_w;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      warm_stable_q <= 1'b0;
      cold_stable_q <= 1'b0;
    end else begin
      if (warm_agree_w) begin
        warm_stable_q <= warm_q[2];
      end
      if (cold_agree_w) begin
        cold_stable_q <= cold_q[2];
      end
    end
  end

  // Load configuration after reset or restart only
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_q          <= '{RST_BASE, RST_TOTAL, RST_START, RST_LEN};
      load_pending_q <= 1'b1;
    end else if (load_pending_q || restart_w) begin
      cfg_q          <= config_i;
      load_pending_q <= 1'b0;
    end
  end

  wire [IDX_W-1:0] total_w = (cfg_q.command_total > IDX_W'(MAX_COMMANDS)) ?
                             IDX_W'(MAX_COMMANDS) : cfg_q.command_total;

  logic              parse_fault_w;
  logic [WORD_W-1:0] parse_code_w;
  mcet_entry_check u_check (
    .entry_i       (master_command_entry_i),
    .max_address_i (max_address_i),
    .fault_o       (parse_fault_w),
    .code_o        (parse_code_w)
  );

  wire [WORD_W-1:0] exc_code_w = {8'h00, result_i.exception_code};
  wire [WORD_W-1:0] result_code_w =
      (result_i.outcome == MCET_OUT_EXCEPTION) ? exc_code_w     :
      (result_i.outcome == MCET_OUT_NO_CTS)    ? CODE_CTS       :
      (result_i.outcome == MCET_OUT_TX_TMO)    ? CODE_TX_TMO    :
      (result_i.outcome == MCET_OUT_RSP_TMO)   ? CODE_RSP_TMO   :
      (result_i.outcome == MCET_OUT_BAD_ADDR)  ? CODE_BAD_ADDR  :
      (result_i.outcome == MCET_OUT_BAD_FUNC)  ? CODE_BAD_FUNC  :
      (result_i.outcome == MCET_OUT_BAD_CHECK) ? CODE_BAD_CHECK : CODE_OK;

  // Results win over a parse report in the same cycle
  wire              use_result_w = result_valid_i;
  wire [IDX_W-1:0]  wr_index_w   = use_result_w ? result_i.index : entry_index_i;
  // Codes are stored as 16-bit words
  wire [WORD_W-1:0] wr_code_w    = use_result_w ? result_code_w : parse_code_w;
  wire [ADDR_W:0]   wr_sum_w     = {1'b0, cfg_q.error_table_base} +
                                   {{(ADDR_W+1-IDX_W){1'b0}}, wr_index_w};
  // Only indices below the command total
  wire wr_en_w = (result_valid_i || entry_valid_i) && !load_pending_q &&
                 (wr_index_w < total_w) &&
                 (wr_sum_w < (ADDR_W+1)'(DEPTH));

  always_ff @(posedge clk_i) begin
    if (wr_en_w) begin
      mem_q[wr_sum_w[ADDR_W-1:0]] <= wr_code_w;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      write_strobe_o  <= 1'b0;
      write_address_o <= '0;
      last_code_o     <= CODE_OK;
      config_loaded_o <= 1'b0;
    end else begin
      write_strobe_o  <= wr_en_w;
      config_loaded_o <= !load_pending_q;
      if (wr_en_w) begin
        write_address_o <= wr_sum_w[ADDR_W-1:0];
        last_code_o     <= wr_code_w;
      end
    end
  end

  // Processor index maps to start plus index
  wire [ADDR_W:0] rd_sum_w = {1'b0, cfg_q.read_window_start} + {1'b0, proc_index_i};
  wire rd_in_w = ({1'b0, proc_index_i} < cfg_q.read_window_length) &&
                 (rd_sum_w < (ADDR_W+1)'(DEPTH));
  wire              rd_take_w = proc_read_i && rd_in_w;
  wire [WORD_W-1:0] rd_word_w = mem_q[rd_in_w ? rd_sum_w[ADDR_W-1:0] : '0];

  // Out-of-window reads return zero
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      proc_valid_o           <= 1'b0;
      proc_in_window_o       <= 1'b0;
      processor_read_array_o <= '0;
    end else begin
      proc_valid_o           <= proc_read_i;
      proc_in_window_o       <= rd_take_w;
      processor_read_array_o <= rd_take_w ? rd_word_w : '0;
    end
  end

  a_total_bound: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_en_w |-> (wr_index_w < total_w) && (total_w <= IDX_W'(MAX_COMMANDS)))
    else $error("write beyond command total");
  a_addr_map: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_en_w |=> write_strobe_o &&
      (write_address_o == ADDR_W'($past(cfg_q.error_table_base) + $past(wr_index_w))))
    else $error("error table address mismatch");
  a_rsp_tmo: assert property (@(posedge clk_i) disable iff (reset_i)
    (wr_en_w && result_valid_i && result_i.outcome == MCET_OUT_RSP_TMO)
      |=> last_code_o == 16'hFFF5)
    else $error("response timeout code wrong");
  a_ok_zero: assert property (@(posedge clk_i) disable iff (reset_i)
    (wr_en_w && result_valid_i && result_i.outcome == MCET_OUT_OK)
      |=> last_code_o == 16'h0000)
    else $error("success code not zero");
  a_check_code: assert property (@(posedge clk_i) disable iff (reset_i)
    (wr_en_w && result_valid_i && result_i.outcome == MCET_OUT_BAD_CHECK)
      |=> last_code_o == 16'h00FF)
    else $error("checksum code wrong");
  a_zero_entry: assert property (@(posedge clk_i) disable iff (reset_i)
    (wr_en_w && !result_valid_i && master_command_entry_i == '0)
      |=> last_code_o == 16'hFFD4)
    else $error("unconfigured entry code wrong");
  a_cfg_hold: assert property (@(posedge clk_i) disable iff (reset_i)
    (!load_pending_q && !restart_w) |=> $stable(cfg_q))
    else $error("configuration changed without restart");
  a_db_bound: assert property (@(posedge clk_i) disable iff (reset_i)
    write_strobe_o |-> (write_address_o < ADDR_W'(DEPTH)))
    else $error("write outside database");
  a_window: assert property (@(posedge clk_i) disable iff (reset_i)
    (proc_read_i && ({1'b0, proc_index_i} >= cfg_q.read_window_length)) |=>
      !proc_in_window_o && processor_read_array_o == '0)
    else $error("read outside window not refused");
  a_exc_code: assert property (@(posedge clk_i) disable iff (reset_i)
    (wr_en_w && result_valid_i && result_i.outcome == MCET_OUT_EXCEPTION)
      |=> last_code_o == {8'h00, $past(result_i.exception_code)})
    else $error("exception code not recorded");
  a_cts_code: assert property (@(posedge clk_i) disable iff (reset_i)
    (wr_en_w && result_valid_i && result_i.outcome == MCET_OUT_NO_CTS)
      |=> last_code_o == 16'hFFFF)
    else $error("clear-to-send code wrong");
  a_tx_code: assert property (@(posedge clk_i) disable iff (reset_i)
    (wr_en_w && result_valid_i && result_i.outcome == MCET_OUT_TX_TMO)
      |=> last_code_o == 16'hFFFE)
    else $error("transmit timeout code wrong");
  // Parse fault never reads as success
  a_parse_fault: assert property (@(posedge clk_i) disable iff (reset_i)
    (wr_en_w && !result_valid_i && parse_fault_w) |=> last_code_o != 16'h0000)
    else $error("parse fault recorded as success");
endmodule : mcet_error_table
`default_nettype wire

// ---- mcet_pkg.sv ----
// Package for the command error table block: constants, codes and carriers
`default_nettype none
package mcet_pkg;
  localparam int unsigned DB_WORDS      = 5000;
  localparam int unsigned MAX_COMMANDS  = 100;
  localparam int unsigned ADDR_W        = 13;
  localparam int unsigned IDX_W         = 7;
  localparam int unsigned WORD_W        = 16;
  localparam int unsigned NODE_MAX      = 255;
  localparam logic [WORD_W-1:0] CODE_OK        = 16'h0000;
  localparam logic [WORD_W-1:0] CODE_CTS       = 16'hFFFF;
  localparam logic [WORD_W-1:0] CODE_TX_TMO    = 16'hFFFE;
  localparam logic [WORD_W-1:0] CODE_RSP_TMO   = 16'hFFF5;
  localparam logic [WORD_W-1:0] CODE_BAD_ADDR  = 16'h00FD;
  localparam logic [WORD_W-1:0] CODE_BAD_FUNC  = 16'h00FE;
  localparam logic [WORD_W-1:0] CODE_BAD_CHECK = 16'h00FF;
  localparam logic [WORD_W-1:0] CODE_P_ENABLE  = 16'hFFD7;
  localparam logic [WORD_W-1:0] CODE_P_ADDR    = 16'hFFD6;
  localparam logic [WORD_W-1:0] CODE_P_NODE    = 16'hFFD5;
  localparam logic [WORD_W-1:0] CODE_P_COUNT   = 16'hFFD4;
  localparam logic [WORD_W-1:0] CODE_P_FUNC    = 16'hFFD3;
  localparam logic [WORD_W-1:0] CODE_P_SWAP    = 16'hFFD2;
  localparam logic [2:0] EXC_MIN = 3'h1;
  localparam logic [2:0] EXC_MAX = 3'h6;
  localparam logic [ADDR_W-1:0] RST_BASE  = 13'h0000;
  localparam logic [IDX_W-1:0]  RST_TOTAL = 7'h00;
  localparam logic [ADDR_W-1:0] RST_START = 13'h0000;
  localparam logic [ADDR_W:0]   RST_LEN   = 14'h0000;

  // Outcome classes reported by the serial engine for one command
  typedef enum logic [2:0] {
    MCET_OUT_OK        = 3'b000,
    MCET_OUT_EXCEPTION = 3'b001,
    MCET_OUT_NO_CTS    = 3'b010,
    MCET_OUT_TX_TMO    = 3'b011,
    MCET_OUT_RSP_TMO   = 3'b100,
    MCET_OUT_BAD_ADDR  = 3'b101,
    MCET_OUT_BAD_FUNC  = 3'b110,
    MCET_OUT_BAD_CHECK = 3'b111
  } mcet_outcome_t;

  // Configuration loaded on reset or restart
  typedef struct packed {
    logic [ADDR_W-1:0] error_table_base;
    logic [IDX_W-1:0]  command_total;
    logic [ADDR_W-1:0] read_window_start;
    logic [ADDR_W:0]   read_window_length;
  } mcet_config_t;

  // One master command entry as presented for parsing
  typedef struct packed {
    logic [15:0] enable_code;
    logic [15:0] internal_address;
    logic [15:0] node_address;
    logic [15:0] count;
    logic [15:0] function_code;
    logic [15:0] swap_code;
  } mcet_entry_t;

  // Completion report of one transaction
  typedef struct packed {
    logic [IDX_W-1:0] index;
    mcet_outcome_t    outcome;
    logic [7:0]       exception_code;
  } mcet_result_t;
endpackage : mcet_pkg
`default_nettype wire

// ---- mcet_entry_check.sv ----
// Combinational parse check of one master command entry
`default_nettype none
module mcet_entry_check
  import mcet_pkg::*;
(
  input  wire mcet_entry_t      entry_i,
  input  wire logic [15:0]      max_address_i,
  output logic                  fault_o,
  output logic [WORD_W-1:0]     code_o
);
  wire all_zero_w   = (entry_i == '0);
  wire bad_enable_w = (entry_i.enable_code > 16'h0002);
  wire bad_addr_w   = (entry_i.internal_address > max_address_i);
  wire bad_node_w   = ($signed(entry_i.node_address) < 0) ||
                      ($signed(entry_i.node_address) > $signed(16'(NODE_MAX)));
  wire bad_count_w  = (entry_i.count == 16'h0000);
  wire bad_func_w   = !(entry_i.function_code inside
                        {16'h0001, 16'h0002, 16'h0003, 16'h0004,
                         16'h0005, 16'h0006, 16'h000F, 16'h0010});
  wire bad_swap_w   = (entry_i.swap_code > 16'h0003);

  assign code_o  = all_zero_w   ? CODE_P_COUNT  :
                   bad_enable_w ? CODE_P_ENABLE :
                   bad_addr_w   ? CODE_P_ADDR   :
                   bad_node_w   ? CODE_P_NODE   :
                   bad_count_w  ? CODE_P_COUNT  :
                   bad_func_w   ? CODE_P_FUNC   :
                   bad_swap_w   ? CODE_P_SWAP   : CODE_OK;
  assign fault_o = (code_o != CODE_OK);
endmodule : mcet_entry_check
`default_nettype wire

// ---- mcet_slave_model.sv ----
// Model of the serial engine that reports the outcome of each command
`default_nettype none
module mcet_slave_model
  import mcet_pkg::*;
(
  input  wire logic         clk_i,
  output var  mcet_result_t result_o,
  output var  logic         result_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    result_valid_o = 1'b0;
    result_o       = '0;
  end

  // Reports one outcome after wait_cyc idle cycles, prompt or slow
  task automatic respond(input logic [IDX_W-1:0] idx, input mcet_outcome_t oc,
                         input logic [7:0] exc, input int unsigned wait_cyc);
    @(posedge clk_i);
    repeat (wait_cyc) @(posedge clk_i);
    result_valid_o <= 1'b1;
    result_o       <= '{index: idx, outcome: oc, exception_code: exc};
    @(posedge clk_i);
    result_valid_o <= 1'b0;
    result_o       <= '{index: ~idx, outcome: mcet_outcome_t'(~oc), exception_code: ~exc};
  endtask : respond
endmodule : mcet_slave_model
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the command error table
`default_nettype none
`define CHK(got, exp, msg) begin checked++; if ((got) !== (exp)) begin error_cnt++; \
  $display("MISMATCH t=%0t %s", $time, msg); end end
module tb;
  import mcet_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [ADDR_W-1:0] BASE = 13'h05DC;
  localparam logic [ADDR_W-1:0] WOFF = 13'h01F4;
  logic              clk, reset, warm, cold, ent_v, rd, rd_v, in_win, loaded, wr_stb, res_v;
  mcet_config_t      cfg;
  mcet_entry_t       entry;
  mcet_result_t      res;
  logic [15:0]       max_addr;
  logic [IDX_W-1:0]  ent_idx;
  logic [ADDR_W-1:0] rd_idx, wr_addr;
  logic [WORD_W-1:0] rd_data, last_code;
  int                error_cnt, checked, cycles;

  mcet_error_table #(.DEPTH(DB_WORDS)) u_mcet_error_table (
    .clk_i(clk), .reset_i(reset), .warm_restart_request_i(warm),
    .cold_restart_request_i(cold), .config_i(cfg), .max_address_i(max_addr),
    .entry_valid_i(ent_v), .entry_index_i(ent_idx), .master_command_entry_i(entry),
    .result_valid_i(res_v), .result_i(res), .proc_read_i(rd), .proc_index_i(rd_idx),
    .proc_valid_o(rd_v), .processor_read_array_o(rd_data), .proc_in_window_o(in_win),
    .config_loaded_o(loaded), .last_code_o(last_code), .write_strobe_o(wr_stb),
    .write_address_o(wr_addr));
  mcet_slave_model u_slave (.clk_i(clk), .result_o(res), .result_valid_o(res_v));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      test_done();
    end
  end

  // Called at the edge that takes a request
  task automatic expect_write(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] c);
    #1;
    `CHK(wr_stb, 1'b1, "no write strobe")
    `CHK(wr_addr, a, "write address")
    `CHK(last_code, c, "written code")
  endtask : expect_write

  task automatic read_word(input logic [ADDR_W-1:0] k, input logic [WORD_W-1:0] c,
                           input logic w);
    @(posedge clk);
    rd     <= 1'b1;
    rd_idx <= k;
    @(posedge clk);
    rd     <= 1'b0;
    rd_idx <= ~k;
    #1;
    `CHK(rd_v, 1'b1, "read valid")
    `CHK(in_win, w, "window flag")
    `CHK(rd_data, c, "read data")
  endtask : read_word

  task automatic t_exceptions();
    for (int e = 1; e <= 6; e++) begin
      u_slave.respond(7'(e), MCET_OUT_EXCEPTION, 8'(e), 0);
      expect_write(BASE + 13'(e), 16'(e));
      read_word(WOFF + 13'(e), 16'(e), 1'b1);
    end
  endtask : t_exceptions

  task automatic t_link();
    logic [IDX_W-1:0]  idx[7]  = '{7'h03, 7'h0A, 7'h0B, 7'h0C, 7'h0D, 7'h0E, 7'h63};
    mcet_outcome_t     oc[7]   = '{MCET_OUT_OK, MCET_OUT_NO_CTS, MCET_OUT_TX_TMO,
                                   MCET_OUT_RSP_TMO, MCET_OUT_BAD_ADDR, MCET_OUT_BAD_FUNC,
                                   MCET_OUT_BAD_CHECK};
    logic [WORD_W-1:0] code[7] = '{16'h0000, 16'hFFFF, 16'hFFFE, 16'hFFF5, 16'h00FD,
                                   16'h00FE, 16'h00FF};
    for (int i = 0; i < 7; i++) begin
      u_slave.respond(idx[i], oc[i], 8'h00, (i == 3) ? 20 : 0);
      expect_write(BASE + 13'(idx[i]), code[i]);
    end
    for (int i = 0; i < 7; i++) begin
      read_word(WOFF + 13'(idx[i]), code[i], 1'b1);
    end
  endtask : t_link

  task automatic t_parse();
    mcet_entry_t       good    = '{16'h0001, 16'h000A, 16'h0001, 16'h0001, 16'h0003, 16'h0000};
    mcet_entry_t       e;
    logic [WORD_W-1:0] code[7] = '{16'hFFD4, 16'hFFD7, 16'hFFD6, 16'hFFD5, 16'hFFD4,
                                   16'hFFD3, 16'hFFD2};
    for (int i = 0; i < 7; i++) begin
      e = good;
      case (i)
        0: e = '0;
        1: e.enable_code = 16'h0003;
        2: e.internal_address = 16'h0065;
        3: e.node_address = 16'h0100;
        4: e.count = 16'h0000;
        5: e.function_code = 16'h0007;
        default: e.swap_code = 16'h0004;
      endcase
      @(posedge clk);
      ent_v   <= 1'b1;
      ent_idx <= 7'(20 + i);
      entry   <= e;
      @(posedge clk);
      ent_v   <= 1'b0;
      entry   <= ~e;
      expect_write(BASE + 13'(20 + i), code[i]);
    end
  endtask : t_parse

  task automatic t_refuse();
    u_slave.respond(7'h64, MCET_OUT_OK, 8'h00, 0);
    #1;
    `CHK(wr_stb, 1'b0, "write beyond total")
    read_word(13'h0258, 16'h0000, 1'b0);
  endtask : t_refuse

  task automatic t_restart();
    @(posedge clk);
    cfg.command_total <= 7'h0A;
    u_slave.respond(7'h32, MCET_OUT_OK, 8'h00, 0);
    expect_write(BASE + 13'h0032, 16'h0000);
    @(posedge clk);
    warm <= ~warm;
    repeat (8) @(posedge clk);
    u_slave.respond(7'h32, MCET_OUT_OK, 8'h00, 0);
    #1;
    `CHK(wr_stb, 1'b0, "new total not applied")
    u_slave.respond(7'h09, MCET_OUT_NO_CTS, 8'h00, 0);
    expect_write(BASE + 13'h0009, 16'hFFFF);
    @(posedge clk);
    cfg.command_total <= 7'h64;
    cold <= ~cold;
    repeat (8) @(posedge clk);
    u_slave.respond(7'h32, MCET_OUT_TX_TMO, 8'h00, 0);
    expect_write(BASE + 13'h0032, 16'hFFFE);
  endtask : t_restart

  // Result and parse report in one cycle: result wins
  task automatic t_collide();
    u_slave.respond(7'h1E, MCET_OUT_OK, 8'h00, 0);
    expect_write(BASE + 13'h001E, 16'h0000);
    fork
      u_slave.respond(7'h1F, MCET_OUT_BAD_FUNC, 8'h00, 0);
      begin
        @(posedge clk);
        ent_v   <= 1'b1;
        ent_idx <= 7'h1E;
        entry   <= '0;
        @(posedge clk);
        ent_v   <= 1'b0;
      end
    join
    expect_write(BASE + 13'h001F, 16'h00FE);
    read_word(WOFF + 13'h001E, 16'h0000, 1'b1);
  endtask : t_collide

  // Table moved to the end of the database
  task automatic t_bound();
    @(posedge clk);
    cfg.error_table_base <= 13'h1383;
    warm                 <= ~warm;
    repeat (8) @(posedge clk);
    u_slave.respond(7'h04, MCET_OUT_BAD_ADDR, 8'h00, 0);
    expect_write(13'h1387, 16'h00FD);
    u_slave.respond(7'h05, MCET_OUT_OK, 8'h00, 0);
    #1;
    `CHK(wr_stb, 1'b0, "write past database end")
  endtask : t_bound

  initial begin
    reset    = 1'b1;
    warm     = 1'b0;
    cold     = 1'b0;
    cfg      = '{BASE, 7'h64, 13'h03E8, 14'h0258};
    max_addr = 16'h0064;
    ent_v    = 1'b0;
    ent_idx  = '0;
    entry    = '0;
    rd       = 1'b0;
    rd_idx   = '0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    for (int n = 0; n < 10 && loaded !== 1'b1; n++) @(posedge clk);
    `CHK(loaded, 1'b1, "config not loaded")
    t_exceptions();
    t_link();
    t_parse();
    t_refuse();
    t_collide();
    t_restart();
    t_bound();
    test_done();
  end
endmodule : tb
`default_nettype wire
